// ===== bench/adcrs_core_model.sv
/*
  Conversion core model: ends a conversion CONV_CYC cycles after a start
  pulse, on channel 0, or at once in any cycle the bench holds fire.
  Assumes the bench never fires in the cycle a started conversion ends.
*/
`timescale 1ns/1ps
module adcrs_core_model #(
  parameter int unsigned CONV_CYC = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       conv_start,
  input  wire logic       fire,
  input  wire logic [2:0] fire_ch,
  input  wire logic [9:0] fire_data,
  output logic            conv_done,
  output logic      [2:0] conv_ch,
  output logic      [9:0] conv_data
);
  logic [7:0] cnt_r;
  logic [2:0] ch_r;
  logic [9:0] dat_r;
  logic       auto;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 8'h00;
    end else if (conv_start) begin
      cnt_r <= 8'(CONV_CYC);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // Idle lines show the inverse of the last value, so stale data can
  // never pass for a fresh result.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ch_r  <= 3'h0;
      dat_r <= 10'h000;
    end else if (conv_done) begin
      ch_r  <= conv_ch;
      dat_r <= conv_data;
    end
  end
  assign auto      = (cnt_r == 8'h01);
  assign conv_done = fire | auto;
  assign conv_ch   = fire ? fire_ch : (auto ? 3'h0 : ~ch_r);
  assign conv_data = fire ? fire_data : (auto ? 10'h1E1 : ~dat_r);
endmodule

// ===== bench/adcrs_top_tb.sv
/*
  Bench for the converter flag block: a table of APB accesses, many of them
  on the edge of a completion, then interrupt and sleep cases.
  Assumes zero-wait APB answers and the core model beside the block.
*/
`timescale 1ns/1ps
module adcrs_top_tb;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] v;
    logic [2:0]  c;
    logic [9:0]  d;
  } adcrs_row_t;
  logic        sys_clk = 1'b0, reset = 1'b1, fire = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, conv_done, conv_start, sleep_active, irq;
  logic [2:0]  fire_ch = 3'h0, conv_ch;
  logic [9:0]  fire_data = 10'h0, conv_data;
  int          n_errors = 0, comparisons = 0, cycles = 0, k;
  adcrs_row_t  rows [37];
  adcrs_top adcrs_top_i (.sys_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_done, .conv_ch,
    .conv_data, .conv_start, .sleep_active, .irq);
  adcrs_core_model adcrs_core_model_i (.sys_clk, .reset, .conv_start,
    .fire, .fire_ch, .fire_data, .conv_done, .conv_ch, .conv_data);
  always #50 sys_clk = ~sys_clk;
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The completion, if any, is fired in the access cycle so that it meets
  // the register access at the same edge.
  task automatic apb(input adcrs_row_t r, output logic [31:0] data);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= r.w;
    paddr <= r.a;
    pwdata <= r.v;
    @(posedge sys_clk);
    penable <= 1'b1;
    fire <= (r.d != 10'h0);
    fire_ch <= r.c;
    fire_data <= r.d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    fire <= 1'b0;
  endtask
  initial begin
    rows = '{
      '{0,8'h1C,32'h0,3'h0,10'h0}, '{0,8'h20,32'h0,3'h0,10'h0},
      '{0,8'h2C,32'h0,3'h0,10'h0}, '{1,8'h10,32'hF,3'h0,10'h0},
      '{0,8'h18,32'hF,3'h0,10'h0}, '{0,8'hFC,32'h0,3'h0,10'h155},
      '{0,8'h1C,32'h10001,3'h0,10'h0}, '{0,8'h34,32'h0,3'h0,10'h2AA},
      '{0,8'h1C,32'h30101,3'h0,10'h0}, '{0,8'h1C,32'h10001,3'h0,10'h0},
      '{0,8'h20,32'h2AA,3'h0,10'h0}, '{0,8'h1C,32'h0,3'h0,10'h0},
      '{0,8'h18,32'hF,3'h1,10'h111}, '{0,8'h20,32'h111,3'h7,10'h0F0},
      '{0,8'h1C,32'h0,3'h0,10'h0}, '{0,8'h20,32'h111,3'h0,10'h0},
      '{0,8'h18,32'hF,3'h0,10'h100}, '{0,8'h18,32'hF,3'h3,10'h033},
      '{0,8'h18,32'hF,3'h2,10'h022}, '{0,8'h1C,32'h3000D,3'h0,10'h0},
      '{0,8'h3C,32'h033,3'h0,10'h1AB}, '{0,8'h1C,32'h30105,3'h0,10'h0},
      '{0,8'h18,32'hF,3'h2,10'h222}, '{0,8'h38,32'h222,3'h0,10'h0},
      '{0,8'h1C,32'h30401,3'h2,10'h2CC}, '{0,8'h1C,32'h30005,3'h0,10'h0},
      '{0,8'h18,32'hF,3'h1,10'h111}, '{0,8'h20,32'h111,3'h0,10'h0},
      '{0,8'h1C,32'h20005,3'h3,10'h333}, '{0,8'h1C,32'h1000D,3'h0,10'h0},
      '{1,8'h14,32'h2,3'h3,10'h3C3}, '{0,8'h1C,32'h3080D,3'h0,10'h0},
      '{0,8'h3C,32'h3C3,3'h0,10'h0}, '{0,8'h20,32'h3C3,3'h0,10'h0},
      '{0,8'h18,32'hD,3'h0,10'h0}, '{1,8'h14,32'h8,3'h0,10'h0AA},
      '{0,8'h1C,32'h10105,3'h0,10'h0}};
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("outputs", 32'h0, {28'h0, irq, conv_start, sleep_active, pslverr});
    foreach (rows[i]) begin
      apb(rows[i], rd);
      if (!rows[i].w) chk($sformatf("row %0d", i), rows[i].v, rd);
    end
    @(negedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb('{1,8'h24,32'h10000,3'h0,10'h0}, rd);
    @(negedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb('{0,8'h2C,32'h0,3'h0,10'h0}, rd);
    chk("mask", 32'h10000, rd);
    apb('{0,8'h20,32'h0,3'h0,10'h0}, rd);
    chk("last", 32'h0AA, rd);
    @(negedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb('{1,8'h04,32'h20,3'h0,10'h0}, rd);
    repeat (3) @(posedge sys_clk);
    chk("sleep idle", 32'h0, {31'h0, sleep_active});
    apb('{1,8'h00,32'h2,3'h0,10'h0}, rd);
    @(negedge sys_clk);
    chk("start", 32'h1, {31'h0, conv_start});
    k = 0;
    while (conv_done !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    chk("done", 32'h1, {31'h0, conv_done});
    chk("sleep in conv", 32'h0, {31'h0, sleep_active});
    repeat (3) @(posedge sys_clk);
    chk("sleep after", 32'h1, {31'h0, sleep_active});
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("reset sleep", 32'h0, {31'h0, sleep_active});
    apb('{0,8'h1C,32'h0,3'h0,10'h0}, rd);
    chk("reset status", 32'h0, rd);
    finish_test();
  end
endmodule

// ===== src/adcrs_pkg.sv
/*
  Constants for the converter result and status flag block: channel count,
  data width, register offsets, bit positions and reset values.
  Assumes an APB slave with 32-bit data and one register per aligned word.
*/
package adcrs_pkg;
  localparam int unsigned NCH    = 8;
  localparam int unsigned DW     = 10;
  localparam int unsigned CHW    = 3;
  localparam logic [7:0] OFF_CR   = 8'h00;
  localparam logic [7:0] OFF_MR   = 8'h04;
  localparam logic [7:0] OFF_CHER = 8'h10;
  localparam logic [7:0] OFF_CHDR = 8'h14;
  localparam logic [7:0] OFF_CHSR = 8'h18;
  localparam logic [7:0] OFF_SR   = 8'h1C;
  localparam logic [7:0] OFF_LAST_RESULT_REGISTER = 8'h20;
  localparam logic [7:0] OFF_IER  = 8'h24;
  localparam logic [7:0] OFF_IMR  = 8'h2C;
  localparam logic [7:0] OFF_CDR0 = 8'h30;
  localparam int unsigned CR_START  = 1;
  localparam int unsigned MR_SLEEP  = 5;
  localparam int unsigned SR_OVR_LO = 8;
  localparam int unsigned SR_DATA_READY_FLAG   = 16;
  localparam int unsigned SR_GENERAL_OVERRUN_FLAG  = 17;
  localparam int unsigned SR_SLEEP  = 18;
  localparam logic [31:0] ZERO32  = 32'h0000_0000;
  localparam logic [NCH-1:0] CH_NONE = '0;
endpackage

// ===== src/adcrs_top.sv
/*
  Status flags and result registers of an analog-to-digital converter
  controller, with an APB register slave and one level interrupt.
  Assumes the conversion core pulses conv_done for one sys_clk cycle with
  conv_ch and conv_data on the same clock, and starts a conversion when
  conv_start pulses.
*/
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module adcrs_top (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        conv_done,
  input  wire logic [adcrs_pkg::CHW-1:0]   conv_ch,
  input  wire logic [adcrs_pkg::DW-1:0]    conv_data,
  output logic                             conv_start,
  output logic                             sleep_active,
  output logic                             irq
);
  localparam int unsigned NCH = adcrs_pkg::NCH;
  localparam int unsigned DW  = adcrs_pkg::DW;
  localparam logic [NCH-1:0] CH_NONE = adcrs_pkg::CH_NONE;

  // Channel numbers compare at the width of the core's channel field.
  typedef logic [adcrs_pkg::CHW-1:0] adcrs_ch_t;

  logic [NCH-1:0]   chen_r;
  logic [NCH-1:0]   eoc_r;
  logic [NCH-1:0]   ovr_r;
  logic             data_ready_flag_r;
  logic             general_overrun_flag_r;
  logic [DW-1:0]    last_r;
  logic [DW-1:0]    cdr_r [NCH];
  logic [NCH-1:0]   imr_r;
  logic [2:0]       imr_hi_r;
  logic             sleep_req_r;
  logic             sleep_r;
  logic             start_r;
  logic [31:0]      prdata_r;
  adcrs_ch_t        conv_ch_last_r;

  logic             acc;
  logic             wr;
  logic             rd;
  logic             rd_sr;
  logic             rd_last_result_register;
  logic             rd_cdr;
  logic             cdr_hit;
  logic [NCH-1:0]   rd_cdr_oh;
  logic [NCH-1:0]   dis_oh;
  logic [NCH-1:0]   done_oh;
  logic             store;
  logic [31:0]      sr_val;
  logic [31:0]      rd_val;
  logic [7:0]       cdr_off;

  // Every access completes in its first access cycle.
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = prdata_r;
  assign rd_sr   = rd & (paddr == adcrs_pkg::OFF_SR);
  assign rd_last_result_register = rd & (paddr == adcrs_pkg::OFF_LAST_RESULT_REGISTER);
  assign cdr_off = paddr - adcrs_pkg::OFF_CDR0;
  assign cdr_hit = (paddr >= adcrs_pkg::OFF_CDR0) &
                   (cdr_off[7:2] < 6'(NCH)) & (cdr_off[1:0] == 2'b00);
  assign rd_cdr  = rd & cdr_hit;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_dec
      assign rd_cdr_oh[g] = rd_cdr & (cdr_off[7:2] == 6'(g));
      assign dis_oh[g]    = wr & (paddr == adcrs_pkg::OFF_CHDR) & pwdata[g];
      assign done_oh[g]   = conv_done & (conv_ch == adcrs_ch_t'(g));
    end
  endgenerate

  // A completion on a channel disabled in the same cycle still counts: the
  // conversion was already under way when the channel was disabled.
  assign store = conv_done & chen_r[conv_ch];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chen_r <= adcrs_pkg::CH_NONE;
    end else if (wr && paddr == adcrs_pkg::OFF_CHER) begin
      chen_r <= chen_r | pwdata[NCH-1:0];
    end else if (wr && paddr == adcrs_pkg::OFF_CHDR) begin
      chen_r <= chen_r & ~pwdata[NCH-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      last_r <= '0;
    end else if (store) begin
      last_r <= conv_data;
    end
  end

  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          cdr_r[g] <= '0;
        end else if (store && done_oh[g]) begin
          cdr_r[g] <= conv_data;
        end
      end

      // Set wins over the read clear; a disable blocks the set.
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          eoc_r[g] <= 1'b0;
        end else if (store && done_oh[g] && !dis_oh[g]) begin
          eoc_r[g] <= 1'b1;
        end else if (rd_cdr_oh[g] || dis_oh[g] ||
                     (rd_last_result_register && conv_ch_last_r == adcrs_ch_t'(g))) begin
          eoc_r[g] <= 1'b0;
        end
      end

      // A coincident overrun set wins over the status read clear.
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          ovr_r[g] <= 1'b0;
        end else if (store && done_oh[g] && eoc_r[g] && !rd_cdr_oh[g]) begin
          ovr_r[g] <= 1'b1;
        end else if (rd_sr) begin
          ovr_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      conv_ch_last_r <= '0;
    end else if (store) begin
      conv_ch_last_r <= conv_ch;
    end
  end

  // Data ready depends only on stored data and last-result reads.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_ready_flag_r <= 1'b0;
    end else if (store) begin
      data_ready_flag_r <= 1'b1;
    end else if (rd_last_result_register) begin
      data_ready_flag_r <= 1'b0;
    end
  end

  // Overrun set keeps precedence over the status read clear.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      general_overrun_flag_r <= 1'b0;
    end else if (store && data_ready_flag_r && !rd_last_result_register) begin
      general_overrun_flag_r <= 1'b1;
    end else if (rd_sr) begin
      general_overrun_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      imr_r    <= adcrs_pkg::CH_NONE;
      imr_hi_r <= 3'h0;
    end else if (wr && paddr == adcrs_pkg::OFF_IER) begin
      imr_r    <= pwdata[NCH-1:0];
      imr_hi_r <= pwdata[adcrs_pkg::SR_GENERAL_OVERRUN_FLAG:adcrs_pkg::SR_DATA_READY_FLAG-1];
    end
  end

  // Sleep requested while idle cannot act until a conversion ends, so the
  // request is held and applied at the next completion.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sleep_req_r <= 1'b0;
    end else if (wr && paddr == adcrs_pkg::OFF_MR) begin
      sleep_req_r <= pwdata[adcrs_pkg::MR_SLEEP];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sleep_r <= 1'b0;
    end else if (!sleep_req_r) begin
      sleep_r <= 1'b0;
    end else if (conv_done) begin
      sleep_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr && paddr == adcrs_pkg::OFF_CR &&
                 pwdata[adcrs_pkg::CR_START];
    end
  end

  assign conv_start   = start_r;
  assign sleep_active = sleep_r;
  assign irq = |(eoc_r & imr_r) | (data_ready_flag_r & imr_hi_r[1]) |
               (general_overrun_flag_r & imr_hi_r[2]) | (|ovr_r & imr_hi_r[0]);

  always_comb begin
    sr_val = adcrs_pkg::ZERO32;
    sr_val[NCH-1:0] = eoc_r;
    sr_val[adcrs_pkg::SR_OVR_LO +: NCH] = ovr_r;
    sr_val[adcrs_pkg::SR_DATA_READY_FLAG]  = data_ready_flag_r;
    sr_val[adcrs_pkg::SR_GENERAL_OVERRUN_FLAG] = general_overrun_flag_r;
    sr_val[adcrs_pkg::SR_SLEEP] = sleep_r;
  end

  always_comb begin
    rd_val = adcrs_pkg::ZERO32;
    if (paddr == adcrs_pkg::OFF_SR) begin
      rd_val = sr_val;
    end else if (paddr == adcrs_pkg::OFF_LAST_RESULT_REGISTER) begin
      rd_val[DW-1:0] = last_r;
    end else if (cdr_hit) begin
      rd_val[DW-1:0] = cdr_r[cdr_off[2+:adcrs_pkg::CHW]];
    end else if (paddr == adcrs_pkg::OFF_CHSR) begin
      rd_val[NCH-1:0] = chen_r;
    end else if (paddr == adcrs_pkg::OFF_MR) begin
      rd_val[adcrs_pkg::MR_SLEEP] = sleep_req_r;
    end else if (paddr == adcrs_pkg::OFF_IMR) begin
      rd_val[NCH-1:0] = imr_r;
      rd_val[adcrs_pkg::SR_GENERAL_OVERRUN_FLAG:adcrs_pkg::SR_DATA_READY_FLAG-1] = imr_hi_r;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata_r <= adcrs_pkg::ZERO32;
    end else if (psel && !penable && !pwrite) begin
      // The word is caught in the setup cycle so that it stands at the
      // access edge; an event in the access cycle shows on the next read.
      prdata_r <= rd_val;
    end
  end

  // Data ready and general overrun checks.
  data_ready_only_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_cdr && !rd_last_result_register && data_ready_flag_r |=> data_ready_flag_r)
    else $error("data ready lost on channel read");

  ready_needs_store_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_last_result_register && !store |=> !data_ready_flag_r)
    else $error("data ready kept without stored data");

  ready_on_store_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    store |=> data_ready_flag_r && last_r == $past(conv_data))
    else $error("stored data did not raise ready");

  general_overrun_flag_set_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    store && data_ready_flag_r && !rd_last_result_register |=> general_overrun_flag_r)
    else $error("general overrun not set");

  general_overrun_flag_clr_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_sr && !(store && data_ready_flag_r) |=> !general_overrun_flag_r)
    else $error("general overrun not cleared");

  // Per-channel overrun, completion and result checks.
  ovr_clr_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_sr && !(store && eoc_r[conv_ch]) |=> ovr_r == CH_NONE)
    else $error("channel overrun not cleared");

  ovr_set_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    store && (eoc_r & done_oh & ~rd_cdr_oh) != CH_NONE
    |=> (ovr_r & $past(done_oh)) != CH_NONE)
    else $error("channel overrun not set");

  eoc_own_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (eoc_r & ~rd_cdr_oh & ~dis_oh) != CH_NONE && !rd_last_result_register
    |=> ($past(eoc_r & ~rd_cdr_oh & ~dis_oh) & ~eoc_r) == CH_NONE)
    else $error("foreign completion flag cleared");

  eoc_clr_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_cdr && !store |=> (eoc_r & $past(rd_cdr_oh)) == CH_NONE)
    else $error("channel read left completion set");

  last_result_register_clr_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_last_result_register && !store |=> !eoc_r[$past(conv_ch_last_r)])
    else $error("last read left completion set");

  eoc_dis_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    dis_oh != CH_NONE |=> (eoc_r & $past(dis_oh)) == CH_NONE)
    else $error("disabled channel flagged completion");

  cdr_store_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    store |=> cdr_r[$past(conv_ch)] == $past(conv_data))
    else $error("channel result not stored");

  // Sleep and start checks; an idle request must wait for a completion.
  sequence idle_sleep_s;
    $rose(sleep_req_r) && !conv_done;
  endsequence
  sleep_wait_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    idle_sleep_s |-> !sleep_r)
    else $error("sleep took effect before conversion");

  sleep_set_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    sleep_req_r && conv_done |=> sleep_r)
    else $error("sleep not entered after conversion");

  start_pulse_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    start_r |=> !start_r)
    else $error("start held longer than one cycle");
endmodule
